/* File: rtl/fmcr_top.sv */
// i2c command interpreter and result readout of the flow sensor
// Function
// R1 - start codes 3603, 3608, 3632 start measuring with oxygen, air, mixture
// R2 - reserved start codes are ignored and start nothing
// R3 - mixture code takes argument and checksum; argument is the concentration
// R4 - measuring runs on; each read header returns flow, temp and status
// R5 - host sends no other command while measuring runs
// R6 - first result becomes readable 12 ms after the start
// R7 - read header with no data available is answered with nack
// R8 - read returns nine bytes: flow, crc, temp, crc, status, crc
// R9 - master nack ends the read; sda is released for the rest
// R10 - flow and temperature are signed 16-bit words, high byte first
// R11 - status 15:12 holds index of running start code
// R12 - status 11 shows exponential smoothing has taken over
// R13 - status 10 is 0 in average-until-read, 1 in fixed-N
// R14 - status 9:0 holds 3ff for pure gas or mixture per mille
// R15 - commands are 16 bits high byte first, argument plus checksum
// R16 - a new sample is requested every 0.5 ms while measuring
// R17 - mean for 64 ms after readout, then smoothing by 0.02 seeded
// R18 - checksum computed over each returned data word
`include "fmcr_defines.svh"
`default_nettype none
module fmcr_top
	import fmcr_pkg::*;
#(
	parameter int WARM_CYC = `FMCR_WARM_NS / `FMCR_CLK_NS,
	parameter int SAMPLE_CYC = `FMCR_SAMPLE_NS / `FMCR_CLK_NS,
	parameter int MEAN_CYC = `FMCR_MEAN_NS / `FMCR_CLK_NS
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	input wire logic avg_fixed_n,
	output logic meas_run,
	output logic [3:0] lut_sel,
	output logic sample_tick,
	input wire logic smp_valid,
	output logic smp_ready,
	input wire logic [15:0] smp_flow,
	input wire logic [15:0] smp_temp
);
	initial begin
		if (WARM_CYC < 1 || SAMPLE_CYC < 1 || MEAN_CYC < 1)
			$error("timing counts must be at least one");
	end

	// ======================================================
	// functions
	function automatic logic [7:0] crc8(input logic [15:0] w);
		logic [7:0] c;
		c = `FMCR_CRC_INIT;
		for (int i = 15; i >= 0; i--) begin
			if (c[7] ^ w[i]) c = {c[6:0], 1'b0} ^ `FMCR_CRC_POLY;
			else c = {c[6:0], 1'b0};
		end
		return c;
	endfunction

	function automatic logic [3:0] code_idx(input logic [15:0] c);
		case (c)
			`FMCR_CMD_O2: code_idx = 4'h0;
			`FMCR_CMD_AIR: code_idx = 4'h1;
			`FMCR_CMD_RSV0: code_idx = 4'h2;
			`FMCR_CMD_RSV1: code_idx = 4'h3;
			`FMCR_CMD_RSV2: code_idx = 4'h4;
			`FMCR_CMD_RSV3: code_idx = 4'h5;
			`FMCR_CMD_MIX: code_idx = 4'h6;
			`FMCR_CMD_RSV4: code_idx = 4'h7;
			`FMCR_CMD_RSV5: code_idx = 4'h8;
			default: code_idx = 4'hf;
		endcase
	endfunction

	// ======================================================
	// pin synchronisers and bus events
	logic [1:0] scl_s_q, sda_s_q;
	logic scl_d1_q, sda_d1_q;
	logic scl_r, scl_f, bus_start, bus_stop;

	always_ff @(posedge mclk) begin
		if (srst) begin
			scl_s_q <= 2'h3;
			sda_s_q <= 2'h3;
			scl_d1_q <= 1'b1;
			sda_d1_q <= 1'b1;
		end else begin
			scl_s_q <= {scl_s_q[0], scl_i};
			sda_s_q <= {sda_s_q[0], sda_i};
			scl_d1_q <= scl_s_q[1];
			sda_d1_q <= sda_s_q[1];
		end
	end

	assign scl_r = scl_s_q[1] & ~scl_d1_q;
	assign scl_f = ~scl_s_q[1] & scl_d1_q;
	assign bus_start = scl_s_q[1] & scl_d1_q & sda_d1_q & ~sda_s_q[1];
	assign bus_stop = scl_s_q[1] & scl_d1_q & ~sda_d1_q & sda_s_q[1];

	// ======================================================
	// measurement state
	logic run_q, mixed_q, expo_q, have_q, warm_q;
	logic [3:0] idx_q;
	logic [9:0] conc_q;
	logic signed [15:0] flow_q, temp_q;
	logic [15:0] status;
	logic [71:0] frame;
	logic data_avail;
	logic start_cmd, read_evt;
	logic [3:0] new_idx;
	logic [9:0] new_conc;

	assign status = {idx_q, expo_q, avg_fixed_n, conc_q}; // R11 R12 R13 R14
	assign data_avail = run_q & warm_q & have_q; // R6
	// nine bytes, each word followed by its checksum
	assign frame = {flow_q, crc8(flow_q), temp_q, crc8(temp_q),
		status, crc8(status)}; // R8 R10 R18
	assign meas_run = run_q;
	assign lut_sel = idx_q;

	// ======================================================
	// i2c slave
	fmcr_state_t st_q;
	logic [3:0] bit_q;
	logic [7:0] sh_q;
	logic rw_q, mack_q;
	logic [2:0] nbyte_q;
	logic [7:0] cmd_q [5];
	logic [71:0] out_q;
	logic [15:0] rx_code, rx_arg;

	assign sda_o = 1'b0;
	assign rx_code = {cmd_q[0], cmd_q[1]}; // R15
	assign rx_arg = {cmd_q[2], cmd_q[3]};

	// byte engine: shift on scl rise, drive on scl fall
	always_ff @(posedge mclk) begin
		if (srst) begin
			st_q <= FMCR_IDLE;
			bit_q <= 4'h0;
			sh_q <= 8'h00;
			rw_q <= 1'b0;
			mack_q <= 1'b0;
			nbyte_q <= 3'h0;
			out_q <= '1;
			sda_oe <= 1'b0;
			for (int i = 0; i < 5; i++) cmd_q[i] <= 8'h00;
		end else if (bus_stop) begin
			st_q <= FMCR_IDLE;
			sda_oe <= 1'b0; // R9
		end else if (bus_start) begin
			st_q <= FMCR_ADDR;
			bit_q <= 4'h0;
			nbyte_q <= 3'h0;
			sda_oe <= 1'b0;
		end else if (scl_r) begin
			if (st_q == FMCR_ADDR || st_q == FMCR_WR) begin
				sh_q <= {sh_q[6:0], sda_s_q[1]};
				bit_q <= bit_q + 4'h1;
			end
			if (st_q == FMCR_R_ACK) mack_q <= sda_s_q[1];
		end else if (scl_f) begin
			case (st_q)
				FMCR_ADDR: begin
					if (bit_q == `FMCR_BITS) begin
						rw_q <= sh_q[0];
						if (sh_q[7:1] != `FMCR_I2C_ADDR)
							st_q <= FMCR_IDLE;
						else if (sh_q[0] & ~data_avail)
							st_q <= FMCR_IDLE; // R7
						else begin
							sda_oe <= 1'b1;
							st_q <= FMCR_A_ACK;
						end
					end
				end
				FMCR_A_ACK: begin
					if (rw_q) begin
						sda_oe <= ~frame[71]; // R4
						out_q <= {frame[70:0], 1'b1};
						bit_q <= 4'h1;
						st_q <= FMCR_RD;
					end else begin
						sda_oe <= 1'b0;
						bit_q <= 4'h0;
						st_q <= FMCR_WR;
					end
				end
				FMCR_WR: begin
					if (bit_q == `FMCR_BITS) begin
						if (nbyte_q < `FMCR_ARG_BYTES) begin
							cmd_q[nbyte_q] <= sh_q;
							nbyte_q <= nbyte_q + 3'h1;
						end
						sda_oe <= 1'b1;
						st_q <= FMCR_W_ACK;
					end
				end
				FMCR_W_ACK: begin
					sda_oe <= 1'b0;
					bit_q <= 4'h0;
					st_q <= FMCR_WR;
				end
				FMCR_RD: begin
					if (bit_q == `FMCR_BITS) begin
						sda_oe <= 1'b0;
						st_q <= FMCR_R_ACK;
					end else begin
						sda_oe <= ~out_q[71];
						out_q <= {out_q[70:0], 1'b1};
						bit_q <= bit_q + 4'h1;
					end
				end
				FMCR_R_ACK: begin
					if (mack_q) begin
						sda_oe <= 1'b0;
						st_q <= FMCR_IDLE; // R9
					end else begin
						sda_oe <= ~out_q[71];
						out_q <= {out_q[70:0], 1'b1};
						bit_q <= 4'h1;
						st_q <= FMCR_RD;
					end
				end
				default: st_q <= FMCR_IDLE;
			endcase
		end
	end

	// read header accepted: the averaging window restarts
	assign read_evt = scl_f & (st_q == FMCR_A_ACK) & rw_q;

	// ======================================================
	// command decode at stop of a write transfer
	always_comb begin
		new_idx = code_idx(rx_code); // R11
		new_conc = `FMCR_CONC_PURE; // R14
		start_cmd = 1'b0;
		if (bus_stop && (st_q == FMCR_WR || st_q == FMCR_W_ACK)) begin
			if ((rx_code == `FMCR_CMD_O2 || rx_code == `FMCR_CMD_AIR) &&
				nbyte_q == `FMCR_CMD_BYTES) begin
				start_cmd = 1'b1; // R1
			end else if (rx_code == `FMCR_CMD_MIX &&
				nbyte_q == `FMCR_ARG_BYTES && crc8(rx_arg) == cmd_q[4] &&
				rx_arg <= `FMCR_CONC_MAX) begin
				start_cmd = 1'b1; // R1 R3
				new_conc = rx_arg[9:0]; // R3 R14
			end
			// reserved codes fall through and start nothing R2
		end
	end

	// run, lookup table and concentration
	always_ff @(posedge mclk) begin
		if (srst) begin
			run_q <= 1'b0;
			idx_q <= 4'h0;
			conc_q <= `FMCR_CONC_PURE;
		end else if (start_cmd) begin
			run_q <= 1'b1;
			idx_q <= new_idx;
			conc_q <= new_conc;
		end
	end

	// ======================================================
	// warm-up and sample request timers
	logic [31:0] warm_cnt_q, tick_cnt_q, mean_cnt_q;

	always_ff @(posedge mclk) begin
		if (srst || start_cmd) begin
			warm_cnt_q <= 32'h0;
			warm_q <= 1'b0;
		end else if (run_q && !warm_q) begin
			warm_cnt_q <= warm_cnt_q + 32'h1;
			if (warm_cnt_q == 32'(WARM_CYC - 1)) warm_q <= 1'b1; // R6
		end
	end

	always_ff @(posedge mclk) begin
		if (srst || !run_q || tick_cnt_q == 32'(SAMPLE_CYC - 1))
			tick_cnt_q <= 32'h0;
		else
			tick_cnt_q <= tick_cnt_q + 32'h1;
	end
	assign sample_tick = run_q && tick_cnt_q == 32'(SAMPLE_CYC - 1); // R16

	// ======================================================
	// sample buffer and averaging
	logic b_valid, b_take, div_busy_q;
	logic [31:0] b_data;
	logic signed [31:0] sum_q, diff, step;
	logic signed [31:0] sum_nx;
	logic [15:0] cnt_q, cnt_nx, den_q;
	logic [31:0] num_q, quo_q;
	logic [32:0] rem_q, rem_sh;
	logic [5:0] dstep_q;
	logic neg_q;

	fmcr_buf2 #(.WIDTH(32)) u_buf (
		.mclk(mclk),
		.srst(srst | start_cmd),
		.in_valid(smp_valid & run_q),
		.in_ready(smp_ready),
		.in_data({smp_flow, smp_temp}),
		.out_valid(b_valid),
		.out_ready(~div_busy_q),
		.out_data(b_data)
	);

	assign b_take = b_valid & ~div_busy_q;
	assign diff = 32'(signed'(b_data[31:16])) - 32'(flow_q);
	assign step = (diff * `FMCR_ALPHA) >>> `FMCR_ALPHA_SH;
	assign rem_sh = {rem_q[31:0], num_q[31]};
	// window sum and count including the sample being taken
	assign sum_nx = (read_evt ? 32'sh0 : sum_q)
		+ 32'(signed'(b_data[31:16]));
	assign cnt_nx = (read_evt ? 16'h0 : cnt_q) + 16'h1;

	// window timer: smoothing takes over after 64 ms without readout
	always_ff @(posedge mclk) begin
		if (srst || start_cmd || read_evt || avg_fixed_n) begin
			mean_cnt_q <= 32'h0;
			expo_q <= 1'b0;
		end else if (run_q && !expo_q) begin
			mean_cnt_q <= mean_cnt_q + 32'h1;
			if (mean_cnt_q == 32'(MEAN_CYC - 1)) expo_q <= 1'b1; // R17 R12
		end
	end

	// results: direct in fixed-N, mean then smoothing otherwise
	always_ff @(posedge mclk) begin
		if (srst || start_cmd) begin
			flow_q <= 16'sh0;
			temp_q <= 16'sh0;
			have_q <= 1'b0;
			sum_q <= 32'sh0;
			cnt_q <= 16'h0;
			div_busy_q <= 1'b0;
			num_q <= 32'h0;
			quo_q <= 32'h0;
			rem_q <= 33'h0;
			dstep_q <= 6'h0;
			neg_q <= 1'b0;
			den_q <= 16'h0;
		end else if (div_busy_q) begin
			// a readout mid-divide still restarts the window
			if (read_evt) begin
				sum_q <= 32'sh0;
				cnt_q <= 16'h0;
			end
			// restoring divide, one quotient bit per cycle
			num_q <= {num_q[30:0], 1'b0};
			if (rem_sh >= {17'h0, den_q}) begin
				rem_q <= rem_sh - {17'h0, den_q};
				quo_q <= {quo_q[30:0], 1'b1};
			end else begin
				rem_q <= rem_sh;
				quo_q <= {quo_q[30:0], 1'b0};
			end
			dstep_q <= dstep_q + 6'h1;
			if (dstep_q == 6'd31) begin
				div_busy_q <= 1'b0;
				have_q <= 1'b1;
				if (rem_sh >= {17'h0, den_q})
					flow_q <= neg_q ? -signed'({quo_q[14:0], 1'b1})
						: signed'({quo_q[14:0], 1'b1}); // R17
				else
					flow_q <= neg_q ? -signed'({quo_q[14:0], 1'b0})
						: signed'({quo_q[14:0], 1'b0});
			end
		end else begin
			if (read_evt) begin
				sum_q <= 32'sh0; // new window after each readout
				cnt_q <= 16'h0;
			end
			if (b_take) begin
				temp_q <= signed'(b_data[15:0]); // R10
				if (avg_fixed_n) begin
					flow_q <= signed'(b_data[31:16]); // R13
					have_q <= 1'b1;
				end else if (expo_q) begin
					flow_q <= flow_q + step[15:0]; // R17
					have_q <= 1'b1;
				end else begin
					// arithmetic mean of the window so far
					sum_q <= sum_nx;
					cnt_q <= cnt_nx;
					den_q <= cnt_nx;
					num_q <= sum_nx[31] ? 32'(-sum_nx)
						: 32'(sum_nx);
					neg_q <= sum_nx[31];
					quo_q <= 32'h0;
					rem_q <= 33'h0;
					dstep_q <= 6'h0;
					div_busy_q <= 1'b1; // R17
				end
			end
		end
	end
endmodule // fmcr_top
`default_nettype wire

/* File: rtl/fmcr_defines.svh */
// constants of the flow measurement command and readout block
`ifndef FMCR_DEFINES_SVH
`define FMCR_DEFINES_SVH
// ==========================================================
// bus address and command codes
`define FMCR_I2C_ADDR 7'h29
`define FMCR_CMD_O2 16'h3603
`define FMCR_CMD_AIR 16'h3608
`define FMCR_CMD_RSV0 16'h3615
`define FMCR_CMD_RSV1 16'h361e
`define FMCR_CMD_RSV2 16'h3624
`define FMCR_CMD_RSV3 16'h362f
`define FMCR_CMD_MIX 16'h3632
`define FMCR_CMD_RSV4 16'h3639
`define FMCR_CMD_RSV5 16'h3646
// ==========================================================
// status word layout
`define FMCR_ST_IDX_HI 15
`define FMCR_ST_IDX_LO 12
`define FMCR_ST_EXP 11
`define FMCR_ST_FIXN 10
`define FMCR_CONC_PURE 10'h3ff
`define FMCR_CONC_MAX 16'h03e8
// ==========================================================
// frame lengths
`define FMCR_CMD_BYTES 3'h2
`define FMCR_ARG_BYTES 3'h5
`define FMCR_BITS 4'h8
// ==========================================================
// checksum
`define FMCR_CRC_POLY 8'h31
`define FMCR_CRC_INIT 8'hff
// ==========================================================
// timing, in ns
`define FMCR_CLK_NS 40
`define FMCR_WARM_NS 12000000
`define FMCR_SAMPLE_NS 500000
`define FMCR_MEAN_NS 64000000
// smoothing factor 0.02 in 1/65536 units
`define FMCR_ALPHA 32'sd1311
`define FMCR_ALPHA_SH 16
`endif

/* File: rtl/fmcr_pkg.sv */
// types of the flow measurement command and readout block
`default_nettype none
package fmcr_pkg;
	// ======================================================
	// bus slave states
	typedef enum logic [2:0] {
		FMCR_IDLE, FMCR_ADDR, FMCR_A_ACK, FMCR_WR, FMCR_W_ACK,
		FMCR_RD, FMCR_R_ACK
	} fmcr_state_t;
endpackage
`default_nettype wire

/* File: rtl/fmcr_buf2.sv */
// two-entry buffer between sample source and result logic
`default_nettype none
module fmcr_buf2 #(
	parameter int WIDTH = 32
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	logic [WIDTH-1:0] mem_q [2];
	logic wp_q, rp_q;
	logic [1:0] cnt_q;
	logic push, pop;

	initial begin
		if (WIDTH < 1) $error("width must be positive");
	end

	// honest full and empty
	assign in_ready = (cnt_q != 2'h2);
	assign out_valid = (cnt_q != 2'h0);
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	assign out_data = mem_q[rp_q];

	// storage
	always_ff @(posedge mclk) begin
		if (push) mem_q[wp_q] <= in_data;
	end

	// pointers and fill count
	always_ff @(posedge mclk) begin
		if (srst) begin
			wp_q <= 1'b0;
			rp_q <= 1'b0;
			cnt_q <= 2'h0;
		end else begin
			if (push) wp_q <= ~wp_q;
			if (pop) rp_q <= ~rp_q;
			if (push & ~pop) cnt_q <= cnt_q + 2'h1;
			else if (pop & ~push) cnt_q <= cnt_q - 2'h1;
		end
	end
endmodule // fmcr_buf2
`default_nettype wire

/* File: dv/fmcr_chk_assertions.sv */
// concurrent checks on the ports of the flow sensor block
`default_nettype none
module fmcr_chk #(
	parameter int SAMPLE_CYC = 12500
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe,
	input wire logic avg_fixed_n,
	input wire logic meas_run,
	input wire logic [3:0] lut_sel,
	input wire logic sample_tick,
	input wire logic smp_valid,
	input wire logic smp_ready,
	input wire logic [15:0] smp_flow,
	input wire logic [15:0] smp_temp
);
	timeunit 1ns;
	timeprecision 1ns;
	int gap_q;
	logic seen_q;
	// ==========================================
	// cycles since the last sample tick
	always_ff @(posedge mclk) begin
		if (srst || !meas_run) begin
			gap_q <= 0;
			seen_q <= 1'b0;
		end else if (sample_tick) begin
			gap_q <= 0;
			seen_q <= 1'b1;
		end else begin
			gap_q <= gap_q + 1;
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	// ==========================================
	// port relations
	tick_period_a: assert property (
		sample_tick && seen_q |-> gap_q == SAMPLE_CYC - 1)
		else $error("sample tick spacing wrong");
	tick_late_a: assert property (
		seen_q |-> gap_q < SAMPLE_CYC)
		else $error("sample tick overdue");
	tick_run_a: assert property (
		sample_tick |-> meas_run)
		else $error("sample tick while idle");
	pin_drive_a: assert property (
		sda_oe |-> !sda_o)
		else $error("data pin driven high");
	lut_legal_a: assert property (
		meas_run |-> lut_sel inside {4'h0, 4'h1, 4'h6})
		else $error("running table index illegal");
	lut_hold_a: assert property (
		meas_run && $past(meas_run) |-> $stable(lut_sel))
		else $error("table index moved while running");
	run_hold_a: assert property (
		$fell(meas_run) |-> $past(srst))
		else $error("measuring stopped by itself");
	oe_scl_a: assert property (
		scl_i && $past(scl_i) && $past(scl_i, 2) && $past(scl_i, 3)
		|-> $stable(sda_oe))
		else $error("data pin changed while clock high");
	ready_hold_a: assert property (
		smp_ready && !smp_valid |=> smp_ready)
		else $error("buffer full without a push");
endmodule // fmcr_chk
`default_nettype wire

/* File: dv/fmcr_host.sv */
// i2c bus master model facing the flow sensor block
`default_nettype none
module fmcr_host (
	input wire logic mclk,
	input wire logic sda,
	output logic scl,
	output logic pull
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int H = 8;
	// ==========================================
	// both lines released and pulled up at idle
	initial begin
		scl = 1'b1;
		pull = 1'b0;
	end
	task automatic hw(input int n);
		repeat (n) @(negedge mclk);
	endtask
	// start: data falls while clock high
	task automatic start();
		pull = 1'b1;
		hw(H);
		scl = 1'b0;
	endtask
	// stop: data rises while clock high
	task automatic stop();
		hw(2);
		pull = 1'b1;
		hw(H);
		scl = 1'b1;
		hw(H);
		pull = 1'b0;
		hw(H);
	endtask
	// one bit: data set while clock low, read mid high phase
	task automatic bit_x(input logic b, output logic r);
		hw(2);
		pull = !b;
		hw(H);
		scl = 1'b1;
		hw(H / 2);
		r = sda;
		hw(H / 2);
		scl = 1'b0;
	endtask
	// byte out msb first, then the device answer
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_x(d[i], r);
		bit_x(1'b1, r);
		ack = !r;
	endtask
	// byte in, then our ack or nack
	task automatic rbyte(input logic nack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_x(1'b1, r);
			d[i] = r;
		end
		bit_x(nack, r);
	endtask
endmodule // fmcr_host
`default_nettype wire

/* File: dv/fmcr_top_bench.sv */
// testbench of the flow measurement command and readout block
`include "fmcr_defines.svh"
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
	err_total++; $display("ERROR %s exp %h got %h", n, e, g); end end
module fmcr_top_bench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int SAMPLE_CYC = 20;
	localparam int WARM_CYC = 2000;
	localparam logic [15:0] FLOW = 16'hfe0c;
	localparam logic [15:0] TEMP = 16'h0c35;
	localparam logic [15:0] CONC = 16'h0155;
	logic mclk, srst, pull, scl, sda_w, sda_o, sda_oe, avg_fixed_n;
	logic meas_run, sample_tick, smp_valid, smp_ready, ack;
	logic [3:0] lut_sel;
	logic [15:0] smp_flow, smp_temp;
	logic [7:0] rb [9];
	logic [15:0] rsv [4] = '{`FMCR_CMD_RSV0, `FMCR_CMD_RSV1,
		`FMCR_CMD_RSV2, `FMCR_CMD_RSV3};
	int err_total, samples_checked;
	// open drain data line with pull-up
	assign sda_w = !(pull || (sda_oe && !sda_o));
	fmcr_top #(.WARM_CYC(WARM_CYC), .SAMPLE_CYC(SAMPLE_CYC),
		.MEAN_CYC(400)) dut_u (.mclk(mclk), .srst(srst), .scl_i(scl),
		.sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
		.avg_fixed_n(avg_fixed_n), .meas_run(meas_run), .lut_sel(lut_sel),
		.sample_tick(sample_tick), .smp_valid(smp_valid),
		.smp_ready(smp_ready), .smp_flow(smp_flow), .smp_temp(smp_temp));
	fmcr_host host_u (.mclk(mclk), .sda(sda_w), .scl(scl), .pull(pull));
	// ==========================================
	// clock and sample source, constant payload
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	always @(negedge mclk) smp_valid <= meas_run;
	function automatic logic [7:0] crc8(input logic [15:0] w);
		logic [7:0] c;
		c = `FMCR_CRC_INIT;
		for (int i = 15; i >= 0; i--)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? `FMCR_CRC_POLY : 8'h00);
		return c;
	endfunction
	// reset between commands, since no stop command exists
	task automatic do_reset();
		srst = 1'b1;
		repeat (5) @(negedge mclk);
		srst = 1'b0;
		repeat (4) @(negedge mclk);
	endtask
	// write frame: code, then optional argument and checksum
	task automatic send(input logic [15:0] c, input logic na,
		input logic [15:0] a, input logic [7:0] k);
		host_u.start();
		host_u.wbyte({`FMCR_I2C_ADDR, 1'b0}, ack);
		host_u.wbyte(c[15:8], ack);
		host_u.wbyte(c[7:0], ack);
		if (na) begin
			host_u.wbyte(a[15:8], ack);
			host_u.wbyte(a[7:0], ack);
			host_u.wbyte(k, ack);
		end
		host_u.stop();
	endtask
	// read frame of n bytes, nack on the last
	task automatic rd(input int n);
		host_u.start();
		host_u.wbyte({`FMCR_I2C_ADDR, 1'b1}, ack);
		for (int i = 0; i < n && ack; i++) host_u.rbyte(i == n - 1, rb[i]);
		host_u.stop();
	endtask
	// full nine byte result against the expected words
	task automatic chk_res(input logic [3:0] idx, input logic [9:0] cc,
		input logic ex);
		logic [15:0] st;
		st = {idx, ex, avg_fixed_n, cc};
		rd(9);
		`CHK("read ack", 1'b1, ack)
		`CHK("flow", FLOW, {rb[0], rb[1]})
		`CHK("flow crc", crc8(FLOW), rb[2])
		`CHK("temp", TEMP, {rb[3], rb[4]})
		`CHK("temp crc", crc8(TEMP), rb[5])
		`CHK("status", st, {rb[6], rb[7]})
		`CHK("status crc", crc8(st), rb[8])
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// ==========================================
	// watchdog
	initial begin
		repeat (60000) @(posedge mclk);
		err_total++;
		conclude();
	end
	// ==========================================
	// test sequence
	initial begin
		srst = 1'b1;
		avg_fixed_n = 1'b1;
		smp_flow = FLOW;
		smp_temp = TEMP;
		do_reset();
		rd(1);
		`CHK("idle header", 1'b0, ack)
		foreach (rsv[i]) begin
			send(rsv[i], 1'b0, 16'h0000, 8'h00);
			`CHK("reserved run", 1'b0, meas_run)
		end
		$display("test reserved done");
		for (int g = 0; g < 2; g++) begin
			do_reset();
			send(g ? `FMCR_CMD_AIR : `FMCR_CMD_O2, 1'b0, 16'h0000,
				8'h00);
			`CHK("run", 1'b1, meas_run)
			`CHK("table", 4'(g), lut_sel)
			rd(1);
			`CHK("early header", 1'b0, ack)
			repeat (2 * WARM_CYC) @(negedge mclk);
			chk_res(4'(g), `FMCR_CONC_PURE, 1'b0);
			rd(3);
			`CHK("released", 1'b0, sda_oe)
			chk_res(4'(g), `FMCR_CONC_PURE, 1'b0);
			$display("test pure gas %0d done", g);
		end
		do_reset();
		avg_fixed_n = 1'b0;
		send(`FMCR_CMD_MIX, 1'b1, CONC, crc8(CONC) ^ 8'h01);
		`CHK("bad crc run", 1'b0, meas_run)
		send(`FMCR_CMD_MIX, 1'b1, 16'h03e9, crc8(16'h03e9));
		`CHK("over range run", 1'b0, meas_run)
		send(`FMCR_CMD_MIX, 1'b1, CONC, crc8(CONC));
		`CHK("table", 4'h6, lut_sel)
		repeat (2 * WARM_CYC) @(negedge mclk);
		chk_res(4'h6, CONC[9:0], 1'b1);
		rd(1);
		chk_res(4'h6, CONC[9:0], 1'b0);
		$display("test mixture done");
		conclude();
	end
endmodule // fmcr_top_bench
bind fmcr_top fmcr_chk #(.SAMPLE_CYC(SAMPLE_CYC)) chk_u (.mclk(mclk),
	.srst(srst), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
	.sda_oe(sda_oe), .avg_fixed_n(avg_fixed_n), .meas_run(meas_run),
	.lut_sel(lut_sel), .sample_tick(sample_tick), .smp_valid(smp_valid),
	.smp_ready(smp_ready), .smp_flow(smp_flow), .smp_temp(smp_temp));
`default_nettype wire
